// ### design/output_link_pkg.sv
// package of offsets, reset values and carrier types for the output link registers
package output_link_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_ADDR     = 8'h21;
   localparam logic [7:0] OVERRIDE_ADDR = 8'h22;
   localparam logic [7:0] DRIVER_ADDR   = 8'h27;
   localparam logic [7:0] CLOCK_ADDR    = 8'h28;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_RESET     = 8'h00;
   localparam logic [7:0] OVERRIDE_RESET = 8'h00;
   localparam logic [7:0] DRIVER_RESET   = 8'h00;
   localparam logic [7:0] CLOCK_RESET    = 8'h28;
   localparam logic [7:0] MODE_MASK      = 8'h03;
   localparam logic [7:0] OVERRIDE_MASK  = 8'h01;
   localparam logic [7:0] DRIVER_MASK    = 8'hFF;
   // bit 6 is a strobe, never stored
   localparam logic [7:0] CLOCK_MASK     = 8'h3C;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OVERRIDE_BIT   = 0;
   localparam int SWING_BIT      = 7;
   localparam int REG_CTRL_BIT   = 6;
   localparam int CLK_EN_BIT     = 5;
   localparam int LANE_MSB       = 4;
   localparam int BLOCK_RST_BIT  = 6;
   localparam int RATE_BIT       = 5;
   localparam int INVERT_BIT     = 4;
   localparam int DELAY_MSB      = 3;
   localparam int DELAY_LSB      = 2;
   localparam logic [1:0] ASI_CODE = 2'h3;
   localparam int DELAY_STEP_PS  = 80;

   typedef struct packed {
      logic       swing_boost;
      logic [4:0] lane_enable;
      logic       clock_enable;
      logic       clock_full_rate;
      logic       clock_invert;
      logic [1:0] clock_delay;
   } link_cfg_t;

endpackage : output_link_pkg

// ### design/cfg_field.sv
// one configuration register with masked write and synchronous reset
`timescale 1ns/10ps
module cfg_field #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WR_MASK   = 8'hFF
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] value
);
   // masked bits stay zero, so reserved bits read zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         value <= RESET_VAL;
      end else if (ce && wr) begin
         value <= wdata & WR_MASK;
      end
   end
endmodule : cfg_field

// ### design/output_link_control_regs.sv
// output link configuration registers and driver control
`timescale 1ns/10ps
module output_link_control_regs (
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   input  wire logic [7:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   output logic      [7:0]                reg_rdata,
   input  wire logic                      asi_mode_pin,
   input  wire logic [5:0]                core_driver_enable,
   output output_link_pkg::link_cfg_t     link_cfg,
   output logic                           asi_mode,
   output logic                           output_block_reset
);
   import output_link_pkg::*;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] mode_reg;
   logic [7:0] override_reg;
   logic [7:0] driver_reg;
   logic [7:0] clock_reg;
   logic       wr_mode;
   logic       wr_override;
   logic       wr_driver;
   logic       wr_clock;

   assign wr_mode     = reg_wr && (reg_addr == MODE_ADDR);
   assign wr_override = reg_wr && (reg_addr == OVERRIDE_ADDR);
   assign wr_driver   = reg_wr && (reg_addr == DRIVER_ADDR);
   assign wr_clock    = reg_wr && (reg_addr == CLOCK_ADDR);

   cfg_field #(.RESET_VAL(MODE_RESET), .WR_MASK(MODE_MASK)) u_mode (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_mode),
      .wdata   (reg_wdata),
      .value   (mode_reg)
   );

   cfg_field #(.RESET_VAL(OVERRIDE_RESET), .WR_MASK(OVERRIDE_MASK)) u_override (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_override),
      .wdata   (reg_wdata),
      .value   (override_reg)
   );

   cfg_field #(.RESET_VAL(DRIVER_RESET), .WR_MASK(DRIVER_MASK)) u_driver (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_driver),
      .wdata   (reg_wdata),
      .value   (driver_reg)
   );

   cfg_field #(.RESET_VAL(CLOCK_RESET), .WR_MASK(CLOCK_MASK)) u_clock (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_clock),
      .wdata   (reg_wdata),
      .value   (clock_reg)
   );

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      unique case (reg_addr)
         MODE_ADDR:     next_rdata = mode_reg;
         OVERRIDE_ADDR: next_rdata = override_reg;
         DRIVER_ADDR:   next_rdata = driver_reg;
         CLOCK_ADDR:    next_rdata = clock_reg;
         default:       next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (ce && reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------------
   logic next_asi_mode;

   always_comb begin
      if (override_reg[OVERRIDE_BIT]) begin
         next_asi_mode = (mode_reg[1:0] == ASI_CODE);
      end else begin
         next_asi_mode = asi_mode_pin;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         asi_mode <= 1'b0;
      end else if (ce) begin
         asi_mode <= next_asi_mode;
      end
   end

   // ----------------------------------------------------------------
   // driver and clock configuration
   // ----------------------------------------------------------------
   link_cfg_t next_cfg;

   always_comb begin
      next_cfg.swing_boost = driver_reg[SWING_BIT];
      if (driver_reg[REG_CTRL_BIT]) begin
         next_cfg.clock_enable = driver_reg[CLK_EN_BIT];
         next_cfg.lane_enable  = driver_reg[LANE_MSB:0];
      end else begin
         next_cfg.clock_enable = core_driver_enable[CLK_EN_BIT];
         next_cfg.lane_enable  = core_driver_enable[LANE_MSB:0];
      end
      next_cfg.clock_full_rate = clock_reg[RATE_BIT];
      next_cfg.clock_invert    = clock_reg[INVERT_BIT];
      next_cfg.clock_delay     = clock_reg[DELAY_MSB:DELAY_LSB];
   end

   // registered so the pads see no decode glitches
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         link_cfg <= '0;
      end else if (ce) begin
         link_cfg <= next_cfg;
      end
   end

   // ----------------------------------------------------------------
   // output block reset strobe
   // ----------------------------------------------------------------
   // one-cycle reset pulse
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         output_block_reset <= 1'b0;
      end else if (ce) begin
         output_block_reset <= wr_clock && reg_wdata[BLOCK_RST_BIT];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_asi_pin_path: assert property (
      ce && !override_reg[OVERRIDE_BIT] |=> asi_mode == $past(asi_mode_pin))
      else $error("mode not taken from pin");
   a_asi_reg_code: assert property (
      ce && override_reg[OVERRIDE_BIT] |=> asi_mode == ($past(mode_reg[1:0]) == 2'h3))
      else $error("mode register code misread");
   a_swing_follow: assert property (
      ce |=> link_cfg.swing_boost == $past(driver_reg[7]))
      else $error("swing does not follow bit 7");
   a_core_control: assert property (
      ce && !driver_reg[6] |=> link_cfg.lane_enable == $past(core_driver_enable[4:0]))
      else $error("lanes not under core control");
   a_clock_enable: assert property (
      ce && driver_reg[6] |=> link_cfg.clock_enable == $past(driver_reg[5]))
      else $error("clock driver enable wrong");
   a_lane_enable: assert property (
      ce && wr_driver && reg_wdata[6] ##1 ce
      |=> link_cfg.lane_enable == $past(reg_wdata[4:0], 2))
      else $error("lane enables not from register");
   a_rate_follow: assert property (
      ce && wr_clock ##1 ce |=> link_cfg.clock_full_rate == $past(reg_wdata[5], 2))
      else $error("clock rate wrong");
   a_invert_follow: assert property (
      ce |=> link_cfg.clock_invert == $past(clock_reg[4]))
      else $error("clock polarity wrong");
   a_delay_follow: assert property (
      ce |=> link_cfg.clock_delay == $past(clock_reg[3:2]))
      else $error("clock delay wrong");
   a_clock_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> clock_reg == 8'h28 && driver_reg == 8'h00)
      else $error("reset values wrong");
   a_block_strobe: assert property (
      ce && wr_clock && reg_wdata[6] |=> output_block_reset && clock_reg[6] == 1'b0)
      else $error("block reset strobe missing");
   a_reserved_zero: assert property (
      ce && reg_rd && !(reg_addr inside {8'h21, 8'h22, 8'h27, 8'h28}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // core path must reach the clock driver too, not only the lanes
   a_core_clock: assert property (
      ce && !driver_reg[6] |=> link_cfg.clock_enable == $past(core_driver_enable[5]))
      else $error("clock driver not under core control");

   c_asi_by_reg:   cover property (override_reg[0] && mode_reg[1:0] == 2'h3 ##1 asi_mode);
   c_boost_lanes:  cover property (link_cfg.swing_boost && link_cfg.lane_enable == 5'h1F);
   c_half_invert:  cover property (!link_cfg.clock_full_rate && link_cfg.clock_invert);
   c_block_reset:  cover property (output_block_reset);
   c_asi_by_pin:   cover property (!override_reg[0] && asi_mode_pin ##1 asi_mode);

endmodule : output_link_control_regs

// ### verif/mgmt_host.sv
// management bus host model issuing register writes and reads
`timescale 1ns/10ps
module mgmt_host (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            ce,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   initial begin
      ce        = 1'b1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   // released data is inverted so a stale value never looks valid
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= addr;
      reg_wdata <= data;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~data;
   endtask : wr

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= addr;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      data = reg_rdata;
   endtask : rd

   // clock enable low freezes the block, writes included
   task automatic hold(input logic en);
      @(posedge ref_clk);
      ce <= en;
   endtask : hold
endmodule : mgmt_host

// ### verif/tb.sv
// testbench for the output link configuration registers
`timescale 1ns/10ps
module tb;
   import output_link_pkg::*;
   logic       ref_clk, rst, ce, reg_wr, reg_rd, asi_mode_pin, asi_mode, output_block_reset;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [5:0] core_driver_enable;
   link_cfg_t  link_cfg;
   int         n_fail, n_compared;

   mgmt_host u_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .ce(ce), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   output_link_control_regs u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .asi_mode_pin(asi_mode_pin), .core_driver_enable(core_driver_enable),
      .link_cfg(link_cfg), .asi_mode(asi_mode), .output_block_reset(output_block_reset));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
      u_host.rd(addr, rd_val);
      chk(rd_val, exp);
   endtask : rchk

   // outputs follow a stored write one edge later
   task automatic settle;
      @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic summarize;
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   initial begin
      #1ms;
      n_fail++;
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      n_fail = 0;
      n_compared = 0;
      rst = 1'b1;
      asi_mode_pin = 1'b0;
      core_driver_enable = 6'h00;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      chk(link_cfg.clock_full_rate, 8'h01);
      chk(link_cfg.clock_invert, 8'h00);
      chk(link_cfg.clock_delay, 8'h02);
      chk(link_cfg.clock_enable, 8'h00);
      rchk(DRIVER_ADDR, 8'h00);
      rchk(CLOCK_ADDR, 8'h28);
      rchk(MODE_ADDR, 8'h00);
      rchk(OVERRIDE_ADDR, 8'h00);
      // register control off: core enables pass through
      @(posedge ref_clk) core_driver_enable <= 6'h2A;
      u_host.wr(DRIVER_ADDR, 8'h00);
      settle();
      chk(link_cfg.lane_enable, 8'h0A);
      chk(link_cfg.clock_enable, 8'h01);
      u_host.wr(DRIVER_ADDR, 8'hFF);
      settle();
      chk(link_cfg.swing_boost, 8'h01);
      chk(link_cfg.lane_enable, 8'h1F);
      chk(link_cfg.clock_enable, 8'h01);
      rchk(DRIVER_ADDR, 8'hFF);
      for (int i = 0; i < 5; i++) begin
         u_host.wr(DRIVER_ADDR, 8'h40 | (8'h01 << i));
         settle();
         chk(link_cfg.lane_enable, 8'h01 << i);
         chk(link_cfg.clock_enable, 8'h00);
         chk(link_cfg.swing_boost, 8'h00);
      end
      // reserved bits set on purpose; strobe bit never reads back
      for (int d = 0; d < 4; d++) begin
         u_host.wr(CLOCK_ADDR, 8'hC3 | 8'(d << 2));
         #1;
         chk(output_block_reset, 8'h01);
         settle();
         chk(output_block_reset, 8'h00);
         chk(link_cfg.clock_delay, 8'(d));
         chk(link_cfg.clock_full_rate, 8'h00);
         chk(link_cfg.clock_invert, 8'h00);
         rchk(CLOCK_ADDR, 8'(d << 2));
      end
      u_host.wr(CLOCK_ADDR, 8'h30);
      settle();
      chk(link_cfg.clock_full_rate, 8'h01);
      chk(link_cfg.clock_invert, 8'h01);
      chk(output_block_reset, 8'h00);
      u_host.wr(8'h23, 8'hFF);
      rchk(8'h23, 8'h00);
      u_host.wr(OVERRIDE_ADDR, 8'hFF);
      rchk(OVERRIDE_ADDR, 8'h01);
      @(posedge ref_clk) asi_mode_pin <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         u_host.wr(MODE_ADDR, 8'(m));
         settle();
         chk(asi_mode, m == 3);
      end
      @(posedge ref_clk) asi_mode_pin <= 1'b0;
      settle();
      chk(asi_mode, 8'h01);
      u_host.wr(OVERRIDE_ADDR, 8'h00);
      settle();
      chk(asi_mode, 8'h00);
      @(posedge ref_clk) asi_mode_pin <= 1'b1;
      settle();
      chk(asi_mode, 8'h01);
      // clock enable low: write and strobe must both be ignored
      u_host.hold(1'b0);
      u_host.wr(CLOCK_ADDR, 8'h50);
      #1;
      chk(output_block_reset, 8'h00);
      u_host.hold(1'b1);
      settle();
      chk(link_cfg.clock_full_rate, 8'h01);
      chk(link_cfg.clock_invert, 8'h01);
      rchk(CLOCK_ADDR, 8'h30);
      // second reset in mid-run must restore every register
      @(posedge ref_clk) rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      chk(link_cfg.clock_invert, 8'h00);
      chk(link_cfg.clock_delay, 8'h02);
      chk(link_cfg.lane_enable, 8'h0A);
      chk(link_cfg.swing_boost, 8'h00);
      chk(asi_mode, 8'h01);
      rchk(CLOCK_ADDR, 8'h28);
      rchk(DRIVER_ADDR, 8'h00);
      rchk(MODE_ADDR, 8'h00);
      rchk(OVERRIDE_ADDR, 8'h00);
      summarize();
   end
endmodule : tb
